// *** logic/ifl_irq_flags.sv ***
/*
 * ifl_irq_flags: interrupt source flags, enables, global gating, wake-up
 * from sleep, vector request with dummy cycles, reset cause bit, apb regs.
 * assumes: one 100 MHz clock, synchronous active-high reset, apb master
 * on the same clock, peripheral event pulses on the same clock, external
 * irq pin and port pins asynchronous.
 */
// Operation
// [RQ1] external pin edge: rising when polarity bit 6 set, falling when clear
// [RQ2] qualifying external edge sets external edge flag, control bit 1
// [RQ3] external edge interrupt masked while enable bit 4 is clear
// [RQ4] software clears external edge flag itself before re-enabling
// [RQ5] external edge wakes sleep only if enabled before sleep began
// [RQ6] after interrupt wake, vector only if global enable, else continue
// [RQ7] taken interrupt loads program counter with vector 0004h
// [RQ8] timer rollover ffh to 00h sets timer overflow flag, bit 2
// [RQ9] timer overflow interrupt enabled by control bit 5
// [RQ10] level change on monitored input sets pin change flag, bit 0
// [RQ11] pin change interrupt enabled by control bit 3
// [RQ12] per-pin mask register; only enabled pins feed pin change flag
// [RQ13] pin change at the q2 port read may be missed
// [RQ14] conversion complete sets conversion done flag, peripheral bit 6
// [RQ15] conversion done interrupt enabled by peripheral enable bit 6
// [RQ16] latency 3 instruction cycles synchronous, 3 to 4 asynchronous
// [RQ17] external flag sampled each q1, may be set during q4 through q1
// [RQ18] wake sets waking source flag: bits 7, 6, 3, 0 of peripheral flags
// [RQ19] brown-out reset clears reset cause bit 0; others leave it (power-on here clears the whole register)
// [RQ20] unimplemented register bits read zero
// [RQ21] vector request needs global enable and some flag with enable
// [RQ22] vectoring clears global enable and inserts two dummy cycles
`timescale 1ns/1ps

module ifl_irq_flags
  import ifl_pkg::*;
#(
  parameter int PINS = 6
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic ext_irq_pin,
  input wire logic [PINS-1:0] port_pins,
  // peripheral events, one-cycle pulses on clock
  input wire logic timer_rollover,
  input wire ifl_periph_evt_type periph_evt,
  input wire ifl_reset_cause_type reset_cause,
  // core sequencer
  input wire logic sleep_req,
  input wire logic core_step_done,
  output logic core_sleeping,
  output logic core_wake,
  output logic vector_load,
  output logic [12:0] vector_addr,
  output logic dummy_cycle,
  output logic [1:0] phase
);

  // ************************************************************
  // phase divider and pin synchronisers
  // ************************************************************
  ifl_phase_type phase_ff;
  logic [1:0] ext_sync_ff;
  logic ext_prev_ff;
  logic [PINS-1:0] pin_s1_ff, pin_s2_ff, pin_prev_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
      phase_ff <= PH_Q1;
    else
      phase_ff <= ifl_phase_type'(phase_ff + 2'h1);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ext_sync_ff <= 2'h0;
      ext_prev_ff <= 1'b0;
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_prev_ff <= '0;
    end
    else
    begin
      ext_sync_ff <= {ext_sync_ff[0], ext_irq_pin};
      ext_prev_ff <= ext_sync_ff[1];
      pin_s1_ff <= port_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] ctrl_ff, pflag_ff, pen_ff, pmask_ff, edge_cfg_ff, rcause_ff;
  logic [7:0] nxt_ctrl, nxt_pflag;
  logic sleeping_ff, ext_en_at_sleep_ff, vec_pend_ff;
  logic [1:0] dummy_cnt_ff;
  // read by the control register logic ahead of its assign
  logic vector_go;

  wire wr = psel && penable && pwrite;
  wire wr_ctrl = wr && (paddr == OFS_IRQ_CTRL);
  wire wr_pflag = wr && (paddr == OFS_PERIPH_FLAG);

  // edge detect on the second sync stage only
  wire ext_rise = ext_sync_ff[1] && !ext_prev_ff;
  wire ext_fall = !ext_sync_ff[1] && ext_prev_ff;
  wire ext_edge = edge_cfg_ff[BIT_EDGE_POL] ? ext_rise : ext_fall; // [RQ1]
  // flag may set only in q4 or q1; an edge elsewhere is held until then
  logic ext_hold_ff;
  wire ext_win = (phase_ff == PH_Q4) || (phase_ff == PH_Q1); // [RQ17]
  wire ext_set = (ext_edge || ext_hold_ff) && ext_win;
  // port read at q2 start hides a change in that cycle; rare miss accepted
  wire pin_chg = |((pin_s2_ff ^ pin_prev_ff) & pmask_ff[PINS-1:0]) // [RQ12]
    && (phase_ff != PH_Q2); // [RQ13]

  always_ff @(posedge clock)
  begin
    if (rst)
      ext_hold_ff <= 1'b0;
    else
      ext_hold_ff <= (ext_edge || ext_hold_ff) && !ext_win;
  end

  // set wins over a software clear in the same cycle
  always_comb
  begin
    nxt_ctrl = wr_ctrl ? (pwdata[7:0] & CTRL_IMPL_MASK) : ctrl_ff; // [RQ20]
    if (ext_set)
      nxt_ctrl[BIT_EXT_FLAG] = 1'b1; // [RQ2]
    if (timer_rollover)
      nxt_ctrl[BIT_TMR_FLAG] = 1'b1; // [RQ8]
    if (pin_chg)
      nxt_ctrl[BIT_PIN_FLAG] = 1'b1; // [RQ10]
    if (vector_go)
      nxt_ctrl[BIT_GIE] = 1'b0; // [RQ22]
  end

  always_comb
  begin
    nxt_pflag = wr_pflag ? (pwdata[7:0] & PF_IMPL_MASK) : pflag_ff;
    if (periph_evt.conversion)
      nxt_pflag[BIT_PF_CONV] = 1'b1; // [RQ14] [RQ18]
    if (periph_evt.mem_write)
      nxt_pflag[BIT_PF_MEM] = 1'b1; // [RQ18]
    if (periph_evt.comparator)
      nxt_pflag[BIT_PF_CMP] = 1'b1; // [RQ18]
    if (periph_evt.rollover)
      nxt_pflag[BIT_PF_ROLL] = 1'b1; // [RQ18]
  end

  // ************************************************************
  // pending, wake-up and vectoring
  // ************************************************************
  wire ext_act = ctrl_ff[BIT_EXT_FLAG] && ctrl_ff[BIT_EXT_EN]; // [RQ3]
  wire tmr_act = ctrl_ff[BIT_TMR_FLAG] && ctrl_ff[BIT_TMR_EN]; // [RQ9]
  wire pin_act = ctrl_ff[BIT_PIN_FLAG] && ctrl_ff[BIT_PIN_EN]; // [RQ11]
  wire per_act = |(pflag_ff & pen_ff & PF_IMPL_MASK); // [RQ15]
  // external source wakes only with its enable captured at sleep entry
  wire wake_src = (ctrl_ff[BIT_EXT_FLAG] && ext_en_at_sleep_ff) // [RQ5]
    || tmr_act || pin_act || per_act;
  wire any_act = ext_act || tmr_act || pin_act || per_act;
  wire irq_req = ctrl_ff[BIT_GIE] && any_act; // [RQ21]
  wire q1 = (phase_ff == PH_Q1);
  // request is sampled at q1 after the current instruction step
  assign vector_go = q1 && irq_req && !vec_pend_ff
    && (core_step_done || sleeping_ff); // [RQ6] [RQ16]
  wire wake_now = sleeping_ff && q1 && wake_src;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_ff <= RST_IRQ_CTRL;
      pflag_ff <= 8'h00;
      pen_ff <= 8'h00;
      pmask_ff <= 8'h00;
      edge_cfg_ff <= RST_EDGE_CFG;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      pflag_ff <= nxt_pflag;
      if (wr && paddr == OFS_PERIPH_EN)
        pen_ff <= pwdata[7:0] & PF_IMPL_MASK; // [RQ20]
      if (wr && paddr == OFS_PIN_MASK)
        pmask_ff <= pwdata[7:0] & PIN_IMPL_MASK; // [RQ20]
      if (wr && paddr == OFS_EDGE_CFG)
        edge_cfg_ff <= pwdata[7:0];
    end
  end

  // reset cause: the sync reset only clears the block, the cause bit keeps
  always_ff @(posedge clock)
  begin
    if (reset_cause.power_on)
      rcause_ff <= 8'h00;
    else if (reset_cause.brown_out)
      rcause_ff[BIT_BROWN] <= 1'b0; // [RQ19]
    else if (wr && paddr == OFS_RESET_CAUSE)
      rcause_ff <= pwdata[7:0] & RC_IMPL_MASK;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sleeping_ff <= 1'b0;
      ext_en_at_sleep_ff <= 1'b0;
      vec_pend_ff <= 1'b0;
      dummy_cnt_ff <= 2'h0;
      core_wake <= 1'b0;
      vector_load <= 1'b0;
      dummy_cycle <= 1'b0;
    end
    else
    begin
      core_wake <= wake_now;
      if (sleep_req && !sleeping_ff)
      begin
        sleeping_ff <= 1'b1;
        ext_en_at_sleep_ff <= ctrl_ff[BIT_EXT_EN]; // [RQ5]
      end
      else if (wake_now)
        sleeping_ff <= 1'b0; // [RQ6]
      vector_load <= 1'b0;
      if (vector_go)
      begin
        vec_pend_ff <= 1'b1;
        dummy_cnt_ff <= 2'(DUMMY_CYCLES);
        dummy_cycle <= 1'b1;
      end
      else if (vec_pend_ff && phase_ff == PH_Q4)
      begin
        if (dummy_cnt_ff == 2'h1)
        begin
          vec_pend_ff <= 1'b0;
          dummy_cycle <= 1'b0;
          vector_load <= 1'b1; // [RQ7] [RQ22]
        end
        dummy_cnt_ff <= dummy_cnt_ff - 2'h1;
      end
    end
  end

  // ************************************************************
  // apb read path, zero wait states
  // ************************************************************
  wire [7:0] core_stat = {6'h00, vec_pend_ff, sleeping_ff};
  logic [7:0] rd_mux;
  wire mapped = (paddr == OFS_IRQ_CTRL) || (paddr == OFS_PERIPH_FLAG)
    || (paddr == OFS_PERIPH_EN) || (paddr == OFS_PIN_MASK)
    || (paddr == OFS_EDGE_CFG) || (paddr == OFS_RESET_CAUSE)
    || (paddr == OFS_CORE_STAT);

  always_comb
  begin
    case (paddr)
      OFS_IRQ_CTRL: rd_mux = ctrl_ff;
      OFS_PERIPH_FLAG: rd_mux = pflag_ff;
      OFS_PERIPH_EN: rd_mux = pen_ff;
      OFS_PIN_MASK: rd_mux = pmask_ff;
      OFS_EDGE_CFG: rd_mux = edge_cfg_ff;
      OFS_RESET_CAUSE: rd_mux = rcause_ff & RC_IMPL_MASK;
      OFS_CORE_STAT: rd_mux = core_stat;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  assign core_sleeping = sleeping_ff;
  assign vector_addr = VECTOR_ADDR;
  assign phase = phase_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  AST_EXT_RISE: assert property (@(posedge clock) disable iff (rst) // [RQ1]
    (ext_rise && edge_cfg_ff[BIT_EDGE_POL] && ext_win)
      |=> ctrl_ff[BIT_EXT_FLAG])
    else $error("rising edge did not set external flag");
  AST_EXT_WIN: assert property (@(posedge clock) disable iff (rst) // [RQ17]
    $rose(ctrl_ff[BIT_EXT_FLAG]) && !$past(wr_ctrl)
      |-> $past(phase_ff) inside {PH_Q4, PH_Q1})
    else $error("external flag set outside q4 to q1");
  AST_TMR: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    timer_rollover |=> ctrl_ff[BIT_TMR_FLAG])
    else $error("timer overflow flag not set");
  AST_MASK: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    (!ctrl_ff[BIT_EXT_EN] && !tmr_act && !pin_act && !per_act)
      |-> !vector_go)
    else $error("masked source caused vectoring");
  AST_GIE: assert property (@(posedge clock) disable iff (rst) // [RQ21]
    $rose(dummy_cycle) |-> $past(ctrl_ff[BIT_GIE]) && $past(any_act))
    else $error("vector without global enable");
  AST_DUMMY: assert property (@(posedge clock) disable iff (rst) // [RQ22]
    vector_go |=> !ctrl_ff[BIT_GIE] ##[1:8] vector_load)
    else $error("vector load not after dummy cycles");
  AST_CONV: assert property (@(posedge clock) disable iff (rst) // [RQ14]
    periph_evt.conversion |=> pflag_ff[BIT_PF_CONV])
    else $error("conversion flag not set");
  AST_RSV: assert property (@(posedge clock) disable iff (rst) // [RQ20]
    pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("reserved bits read nonzero");
  AST_BROWN: assert property (@(posedge clock) // [RQ19]
    reset_cause.brown_out && !reset_cause.power_on
      |=> !rcause_ff[BIT_BROWN])
    else $error("brown-out did not clear cause bit");
  AST_PIN_MASK: assert property (@(posedge clock) disable iff (rst) // [RQ12]
    !(|((pin_s2_ff ^ pin_prev_ff) & pmask_ff[PINS-1:0])) && !wr_ctrl
      && !ctrl_ff[BIT_PIN_FLAG] |=> !ctrl_ff[BIT_PIN_FLAG])
    else $error("masked pin change set pin change flag");
  AST_PIN_SET: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    pin_chg |=> ctrl_ff[BIT_PIN_FLAG])
    else $error("pin change flag not set");
  AST_SLEEP_EN: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    $rose(sleeping_ff) |-> ext_en_at_sleep_ff == $past(ctrl_ff[BIT_EXT_EN]))
    else $error("sleep entry did not capture external enable");
  AST_NO_GIE: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    $rose(core_wake) && !$past(ctrl_ff[BIT_GIE]) |-> !$rose(dummy_cycle))
    else $error("vectored after wake without global enable");
  AST_WAKE: assert property (@(posedge clock) disable iff (rst) // [RQ6]
    wake_now |=> core_wake && !sleeping_ff)
    else $error("wake did not leave sleep");
  AST_CTRL_RSV: assert property (@(posedge clock) disable iff (rst) // [RQ20]
    (ctrl_ff & ~CTRL_IMPL_MASK) == 8'h00)
    else $error("unimplemented control bit set");
  // the vector starts and ends on instruction boundaries
  AST_VEC_Q1: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    $rose(dummy_cycle) |-> $past(phase_ff) == PH_Q1)
    else $error("vectoring began outside q1");
  AST_LOAD_Q1: assert property (@(posedge clock) disable iff (rst) // [RQ22]
    vector_load |-> phase_ff == PH_Q1 && !dummy_cycle)
    else $error("vector load not at instruction boundary");

  // ************************************************************
  // cover points
  // ************************************************************
  COV_VEC: cover property (@(posedge clock) disable iff (rst)
    vector_go ##[1:8] vector_load);
  COV_WAKE: cover property (@(posedge clock) disable iff (rst) wake_now);
  COV_PIN: cover property (@(posedge clock) disable iff (rst) pin_chg);
  COV_WAKE_VEC: cover property (@(posedge clock) disable iff (rst)
    wake_now && vector_go);
  COV_BROWN: cover property (@(posedge clock) reset_cause.brown_out);

endmodule

// *** logic/ifl_pkg.sv ***
/*
 * ifl_pkg: constants, register offsets, field positions and carrier types
 * for the interrupt flag logic.
 * assumes: imported whole by the design module; no timescale here.
 */
package ifl_pkg;

  // ************************************************************
  // register byte offsets (apb, one aligned word each)
  // ************************************************************
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIPH_FLAG = 8'h04;
  localparam logic [7:0] OFS_PERIPH_EN = 8'h08;
  localparam logic [7:0] OFS_PIN_MASK = 8'h0c;
  localparam logic [7:0] OFS_EDGE_CFG = 8'h10;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h14;
  localparam logic [7:0] OFS_CORE_STAT = 8'h18;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_PIN_FLAG = 0;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_PIN_EN = 3;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_GIE = 7;
  localparam int BIT_EDGE_POL = 6;
  localparam int BIT_PF_ROLL = 0;
  localparam int BIT_PF_CMP = 3;
  localparam int BIT_PF_CONV = 6;
  localparam int BIT_PF_MEM = 7;
  localparam int BIT_BROWN = 0;
  localparam int BIT_POWER_ON = 1;
  localparam int BIT_ST_SLEEP = 0;
  localparam int BIT_ST_VEC = 1;

  // ************************************************************
  // masks of implemented bits and reset values
  // ************************************************************
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hbf;
  localparam logic [7:0] PF_IMPL_MASK = 8'hc9;
  localparam logic [7:0] PIN_IMPL_MASK = 8'h3f;
  localparam logic [7:0] RC_IMPL_MASK = 8'h03;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [7:0] RST_EDGE_CFG = 8'hff;
  localparam logic [7:0] TIMER_ROLL_FROM = 8'hff;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;

  // ************************************************************
  // timing: four clock cycles per instruction cycle
  // ************************************************************
  localparam int PHASES_PER_CYCLE = 4;
  localparam int DUMMY_CYCLES = 2;
  localparam int SYNC_LATENCY = 3;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} ifl_phase_type;

  typedef struct packed {
    logic rollover;
    logic comparator;
    logic conversion;
    logic mem_write;
  } ifl_periph_evt_type;

  typedef struct packed {
    logic brown_out;
    logic power_on;
    logic other;
  } ifl_reset_cause_type;

endpackage

// *** testbench/ifl_core_model.sv ***
/*
 * ifl_core_model: stand-in for the core sequencer; retires one
 * instruction per non-dummy instruction cycle and counts vector loads, wakes
 * and dummy cycles for the bench.
 * assumes: same clock and synchronous reset as ifl_irq_flags.
 */
`timescale 1ns/1ps

module ifl_core_model
  import ifl_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // from the flag logic
  input wire logic [1:0] phase,
  input wire logic dummy_cycle,
  input wire logic vector_load,
  input wire logic core_wake,
  // to the flag logic and the bench
  output logic core_step_done,
  output int vec_n,
  output int wake_n,
  output int dummy_n
);
  // ************************************************************
  // instruction retire and event counts
  // ************************************************************
  // nothing retires in a dummy cycle, so a vector is never stacked
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      core_step_done <= 1'b0;
      vec_n <= 0;
      wake_n <= 0;
      dummy_n <= 0;
    end
    else
    begin
      core_step_done <= (phase == PH_Q4) && !dummy_cycle;
      vec_n <= vec_n + int'(vector_load === 1'b1);
      wake_n <= wake_n + int'(core_wake === 1'b1);
      dummy_n <= dummy_n + int'(dummy_cycle === 1'b1);
    end
  end
endmodule

// *** testbench/tb_ifl_irq_flags.sv ***
/*
 * tb_ifl_irq_flags: self-checking bench for the interrupt flag logic,
 * apb register tasks and scenario sequences.
 * assumes: ifl_pkg and ifl_irq_flags compiled first; core model beside.
 */
`timescale 1ns/1ps

module tb_ifl_irq_flags
  import ifl_pkg::*;
;
  logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdata;
  logic pready, pslverr, rerr, ext_irq_pin = 0, timer_rollover = 0;
  logic [5:0] port_pins = '0;
  ifl_periph_evt_type periph_evt = '0;
  ifl_reset_cause_type reset_cause = '0;
  logic sleep_req = 0, core_step_done, core_sleeping, core_wake;
  logic vector_load, dummy_cycle;
  logic [12:0] vector_addr;
  logic [1:0] phase;
  int vec_n, wake_n, dummy_n, bad_count = 0, n_checks = 0;
  int cyc = 0, vec_at = 0, t0, v0, w0, d0;
  logic [7:0] cv [2] = '{8'h10, 8'h90};
  logic [7:0] tv [3] = '{8'ha0, 8'h20, 8'h80};

  always #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (vector_load === 1'b1) vec_at = cyc;
  end

  ifl_irq_flags ifl_irq_flags_inst (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .port_pins(port_pins), .timer_rollover(timer_rollover),
    .periph_evt(periph_evt), .reset_cause(reset_cause),
    .sleep_req(sleep_req), .core_step_done(core_step_done),
    .core_sleeping(core_sleeping), .core_wake(core_wake),
    .vector_load(vector_load), .vector_addr(vector_addr),
    .dummy_cycle(dummy_cycle), .phase(phase));
  ifl_core_model ifl_core_model_inst (.clock(clock), .rst(rst),
    .phase(phase), .dummy_cycle(dummy_cycle),
    .vector_load(vector_load), .core_wake(core_wake),
    .core_step_done(core_step_done), .vec_n(vec_n), .wake_n(wake_n),
    .dummy_n(dummy_n));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 50) check("pready", 0, 1);
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    apb(0, a, 0);
    check(nm, rdata, exp);
  endtask

  task automatic ext_to(input logic v);
    @(posedge clock);
    ext_irq_pin <= v;
    repeat (14) @(posedge clock);
  endtask

  // change pins away from the q2 port read, where a change may be lost
  task automatic pins_to(input logic [5:0] v);
    do @(posedge clock); while (phase !== 2'(PH_Q2));
    port_pins <= v;
    repeat (14) @(posedge clock);
  endtask

  task automatic tmr_pulse();
    @(posedge clock);
    timer_rollover <= 1;
    @(posedge clock);
    timer_rollover <= 0;
  endtask

  task automatic enter_sleep();
    @(posedge clock);
    sleep_req <= 1;
    @(posedge clock);
    sleep_req <= 0;
    repeat (6) @(posedge clock);
    check("sleeping", core_sleeping, 1);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 0;
    rd("ctrl_rst", OFS_IRQ_CTRL, 32'(RST_IRQ_CTRL));
    rd("edge_rst", OFS_EDGE_CFG, 32'(RST_EDGE_CFG));
    rd("unmapped", 8'h1c, 32'h0);
    check("slverr", 32'(rerr), 32'h1);
    wr(OFS_PIN_MASK, 32'hffffffff);
    rd("mask_impl", OFS_PIN_MASK, 32'h3f);
    wr(OFS_PERIPH_EN, 32'hffffffff);
    rd("pen_impl", OFS_PERIPH_EN, 32'hc9);
    wr(OFS_IRQ_CTRL, 32'h40);
    rd("ctrl_impl", OFS_IRQ_CTRL, 32'h00);
    wr(OFS_PERIPH_EN, 32'h0);
    // polarity 1 then 0: qualifying edge sets, opposite edge does not
    for (int p = 1; p >= 0; p--)
    begin
      wr(OFS_EDGE_CFG, p ? 32'hff : 32'hbf);
      ext_to(!p);
      wr(OFS_IRQ_CTRL, 0);
      ext_to(p);
      rd("ext_set", OFS_IRQ_CTRL, 32'h02);
      wr(OFS_IRQ_CTRL, 0);
      ext_to(!p);
      rd("ext_wrong", OFS_IRQ_CTRL, 32'h00);
    end
    tmr_pulse();
    repeat (4) @(posedge clock);
    rd("tmr_flag", OFS_IRQ_CTRL, 32'h04);
    wr(OFS_IRQ_CTRL, 0);
    wr(OFS_PIN_MASK, 32'h01);
    pins_to(6'h02);
    rd("pin_masked", OFS_IRQ_CTRL, 32'h00);
    pins_to(6'h03);
    rd("pin_flag", OFS_IRQ_CTRL, 32'h01);
    wr(OFS_IRQ_CTRL, 0);
    @(posedge clock);
    periph_evt.conversion <= 1;
    @(posedge clock);
    periph_evt.conversion <= 0;
    repeat (4) @(posedge clock);
    rd("conv_flag", OFS_PERIPH_FLAG, 32'h40);
    wr(OFS_PERIPH_FLAG, 0);
    // vector only with global enable and source enable
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_IRQ_CTRL, 32'(tv[i]));
      v0 = vec_n;
      d0 = dummy_n;
      t0 = cyc;
      tmr_pulse();
      repeat (40) @(posedge clock);
      check("vec_n", vec_n - v0, i == 0);
      if (i == 0)
      begin
        check("vec_addr", 32'(vector_addr), 32'h0004);
        // the vectoring q1 itself runs no dummy clock
        check("dummies", dummy_n - d0, 2 * PHASES_PER_CYCLE - 1);
        check("latency", 32'(vec_at - t0 <= 5 * PHASES_PER_CYCLE &&
              vec_at - t0 >= 2 * PHASES_PER_CYCLE), 1);
        rd("gie_clr", OFS_IRQ_CTRL, 32'h24);
      end
      wr(OFS_IRQ_CTRL, 0);
    end
    // falling edge wakes; global enable chooses vector or next
    for (int i = 0; i < 2; i++)
    begin
      ext_to(1);
      wr(OFS_IRQ_CTRL, 32'(cv[i]));
      enter_sleep();
      v0 = vec_n;
      w0 = wake_n;
      ext_to(0);
      repeat (20) @(posedge clock);
      check("wake", wake_n - w0, 1);
      check("wake_vec", vec_n - v0, i);
      wr(OFS_IRQ_CTRL, 0);
    end
    // enable given after sleep entry does not wake; conversion does
    ext_to(1);
    enter_sleep();
    w0 = wake_n;
    wr(OFS_IRQ_CTRL, 32'h10);
    ext_to(0);
    repeat (20) @(posedge clock);
    check("late_en", wake_n - w0, 0);
    rd("stat_sleep", OFS_CORE_STAT, 32'h01);
    wr(OFS_PERIPH_EN, 32'h40);
    @(posedge clock);
    periph_evt.conversion <= 1;
    @(posedge clock);
    periph_evt.conversion <= 0;
    repeat (20) @(posedge clock);
    check("conv_wake", wake_n - w0, 1);
    rd("wake_src", OFS_PERIPH_FLAG, 32'h40);
    // enabled pin change wakes through the pin change enable
    wr(OFS_PERIPH_FLAG, 0);
    wr(OFS_IRQ_CTRL, 32'h08);
    enter_sleep();
    w0 = wake_n;
    pins_to(6'h02);
    repeat (20) @(posedge clock);
    check("pin_wake", wake_n - w0, 1);
    @(posedge clock);
    reset_cause.power_on <= 1;
    @(posedge clock);
    reset_cause.power_on <= 0;
    wr(OFS_RESET_CAUSE, 32'h03);
    @(posedge clock);
    reset_cause.other <= 1;
    @(posedge clock);
    reset_cause.other <= 0;
    rd("rc_other", OFS_RESET_CAUSE, 32'h03);
    @(posedge clock);
    reset_cause.brown_out <= 1;
    @(posedge clock);
    reset_cause.brown_out <= 0;
    rd("rc_brown", OFS_RESET_CAUSE, 32'h02);
    conclude();
  end

  // tests take under a thousand cycles; thirty thousand cycles means a hang
  initial
  begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule
